// file: core/mif_pkg.sv
/*
  Shared constants for the multiplexed memory interface sequencer:
  bus phases, cycle kinds, configuration word layout and refresh timing.
  Assumes a 100 MHz core clock and a 5 MHz reference for refresh counting.
*/
`default_nettype none

package mif_pkg;

  localparam int CLK_NS = 10;
  localparam int CLKIN_NS = 200;
  localparam int CLKIN_CYC = (CLKIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int REF_STEP_CLKIN = 18;
  localparam int REF_CNT_W = 11;
  localparam int REF_ROW_W = 8;

  localparam int AW = 32;
  localparam int DW = 32;
  localparam int BW = 4;

  localparam int CFG_BITS = 9;
  localparam int CFG_IDX_W = 4;
  localparam int CFG_S3_LSB = 0;
  localparam int CFG_S4_LSB = 3;
  localparam int CFG_DLY_W = 3;
  localparam int CFG_EARLY_BIT = 6;
  localparam int CFG_REF_LSB = 7;
  localparam int CFG_REF_W = 2;
  localparam logic [CFG_BITS-1:0] CFG_DEFAULT = 9'h1e4;
  localparam logic [AW-1:0] CFG_BASE = 32'h7fff_ff00;
  localparam logic [AW-1:0] REFRESH_BASE = 32'h0010_0000;
  localparam int ADDR_WORD_LSB = 2;

  localparam int TCNT_W = 4;
  localparam logic [TCNT_W-1:0] TCNT_MAX = 4'hf;

  typedef enum logic [2:0] {
    PH_IDLE = 3'b000,
    PH_T1 = 3'b001,
    PH_T2 = 3'b010,
    PH_T3 = 3'b011,
    PH_T4 = 3'b100,
    PH_TW = 3'b101,
    PH_T5 = 3'b110,
    PH_T6 = 3'b111
  } mif_phase_e;

  typedef enum logic [1:0] {
    KIND_READ = 2'b00,
    KIND_WRITE = 2'b01,
    KIND_REFRESH = 2'b10,
    KIND_CFG = 2'b11
  } mif_kind_e;

endpackage : mif_pkg

`default_nettype wire

// file: core/mif_refresh_timer.sv
/*
  Refresh interval timer: raises a request every programmed interval.
  Assumes the sequencer acknowledges with a one-cycle pulse.
*/
`default_nettype none

module mif_refresh_timer
  import mif_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [CFG_REF_W-1:0] interval_sel,
  input wire logic ack,
  output logic due
);

  logic [REF_CNT_W-1:0] cnt_q;
  logic [REF_CNT_W-1:0] limit;
  logic tick;
  logic due_q;

  // Steps of 18 reference periods; longest setting is 72 periods
  assign limit = REF_CNT_W'((int'(interval_sel) + 1) * REF_STEP_CLKIN
                 * CLKIN_CYC - 1); // see [R5] see [R6]
  assign tick = (cnt_q >= limit);
  assign due = due_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
      due_q <= 1'b0;
    end else begin
      cnt_q <= tick ? '0 : cnt_q + 1'b1;
      // A new interval expiring in the ack cycle is kept, not lost
      due_q <= tick | (due_q & ~ack);
    end
  end

endmodule // mif_refresh_timer

`default_nettype wire

// file: core/mif_core.sv
/*
  Processor-side memory interface sequencer with multiplexed address/data,
  programmable strobes, bit-serial configuration load and refresh cycles.
  Assumes external glue decodes chip selects, gates waits and buffers data.
*/
// Notes on behaviour
// [R1] Early write: write enable low by column strobe
// [R2] Late write looks like read at start
// [R3] Late write needs read-strobe-gated output buffers
// [R4] Column strobe is strobe two, falls at T3
// [R5] Refresh interval covers all rows in time
// [R6] Longest interval is 72 reference clock periods
// [R7] Boot ROM select comes from read strobe
// [R8] Peripheral select from strobe two, stretched by waits
// [R9] Waits sit between T4 and T5
// [R10] Bus released before T1 address phase
// [R11] Data buffers enabled by read/write strobes only
// [R12] Line zero low in T1/T2 on writes
// [R13] Wait input follows strobe four or three
// [R14] Refresh marked by A20 high, A31 low
// [R15] Configuration read bit-serially on data line zero
// [R16] A31 and A20 select bank, I/O, ROM
// [R17] Row strobe reaches both banks every cycle; the code holds strobe one high in configuration load cycles
// [R18] Refresh holds A31 low, blocking column strobes
`default_nettype none

module mif_core
  import mif_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [AW-1:0] req_addr,
  input wire logic [DW-1:0] req_wdata,
  input wire logic [BW-1:0] req_be,
  output logic req_ready,
  output logic rsp_valid,
  output logic [DW-1:0] rsp_rdata,
  input wire logic [DW-1:0] ad_in,
  output logic [DW-1:0] ad_out,
  output logic ad_oe_n,
  output logic addr_latch_strobe_n,
  output logic prog_strobe_one_n,
  output logic prog_strobe_two_n,
  output logic prog_strobe_three_n,
  output logic prog_strobe_four_n,
  output logic read_strobe_n,
  output logic [BW-1:0] byte_write_strobe_n,
  input wire logic wait_request,
  output logic cfg_done
);

  function automatic logic ph_between(mif_phase_e p, mif_phase_e lo,
                                      mif_phase_e hi);
    ph_between = (p >= lo) && (p <= hi);
  endfunction

  function automatic logic dly_reached(logic [TCNT_W-1:0] t,
                                       logic [CFG_DLY_W-1:0] d);
    dly_reached = (t >= {1'b0, d});
  endfunction

  mif_phase_e phase_q, phase_d;
  mif_kind_e kind_q, kind_d;
  logic [TCNT_W-1:0] tcnt_q, tcnt_d;
  logic [AW-1:0] addr_q, addr_d;
  logic [DW-1:0] wdata_q, wdata_d;
  logic [BW-1:0] be_q, be_d;
  logic [REF_ROW_W-1:0] row_q;
  logic [CFG_BITS-1:0] cfg_q, shift_q;
  logic [CFG_IDX_W-1:0] cfg_idx_q;
  logic cfg_mode_q;
  logic [2:0] wait_sync_q;
  logic wait_lvl_q;
  logic ready_q, rsp_valid_q, cfg_done_q, oe_n_q, as_n_q;
  logic s1_n_q, s2_n_q, s3_n_q, s4_n_q, rd_n_q;
  logic [DW-1:0] rdata_q, ad_out_q;
  logic [BW-1:0] wr_n_q;

  // Request handshake and cycle selection
  logic take_req, ref_due, idle, start, ref_ack, last_cfg, t5_end;
  logic [AW-1:0] ref_addr, cfg_addr;

  assign idle = (phase_q == PH_IDLE);
  assign take_req = idle && req_valid && ready_q;
  assign start = idle && (take_req || cfg_mode_q || ref_due);
  assign ref_ack = start && !take_req && !cfg_mode_q;
  assign t5_end = (phase_q == PH_T5);
  assign last_cfg = (cfg_idx_q == CFG_IDX_W'(CFG_BITS - 1));
  // Refresh address keeps A31 low and A20 high for the external decode
  assign ref_addr = REFRESH_BASE
                    | {{(AW-REF_ROW_W-ADDR_WORD_LSB){1'b0}}, row_q,
                       {ADDR_WORD_LSB{1'b0}}}; // see [R14] see [R18]
  assign cfg_addr = CFG_BASE
                    | {{(AW-CFG_IDX_W-ADDR_WORD_LSB){1'b0}}, cfg_idx_q,
                       {ADDR_WORD_LSB{1'b0}}};

  mif_refresh_timer u_refresh (
    .clk(clk),
    .rst_n(rst_n),
    .interval_sel(cfg_q[CFG_REF_LSB +: CFG_REF_W]), // see [R5]
    .ack(ref_ack),
    .due(ref_due)
  );

  always_comb begin
    kind_d = kind_q;
    addr_d = addr_q;
    wdata_d = wdata_q;
    be_d = be_q;
    if (take_req) begin
      kind_d = req_write ? KIND_WRITE : KIND_READ;
      addr_d = req_addr;
      wdata_d = req_wdata;
      be_d = req_be;
    end else if (start && cfg_mode_q) begin
      kind_d = KIND_CFG; // see [R15]
      addr_d = cfg_addr;
      be_d = '0;
    end else if (start) begin
      kind_d = KIND_REFRESH;
      addr_d = ref_addr;
      be_d = '0;
    end
  end

  // Phase sequence; waits are inserted only after T4
  always_comb begin
    case (phase_q)
      PH_IDLE: phase_d = start ? PH_T1 : PH_IDLE;
      PH_T1: phase_d = PH_T2;
      PH_T2: phase_d = PH_T3;
      PH_T3: phase_d = PH_T4;
      PH_T4: phase_d = wait_lvl_q ? PH_TW : PH_T5; // see [R9]
      PH_TW: phase_d = wait_lvl_q ? PH_TW : PH_T5; // see [R9]
      PH_T5: phase_d = PH_T6;
      PH_T6: phase_d = PH_IDLE;
      default: phase_d = PH_IDLE;
    endcase
  end

  // Tm count from T1, saturating; drives the programmable fall points
  assign tcnt_d = (phase_d == PH_T1 || phase_d == PH_IDLE) ? '0 :
                  (tcnt_q == TCNT_MAX) ? tcnt_q : tcnt_q + 1'b1;

  // Strobe decode from the next phase so every pin leaves a flop
  logic addr_ph, act_ph, s1_on, col_on, s3_on, s4_on, rd_on, wr_on;
  logic mem_cyc, early;
  logic [CFG_DLY_W-1:0] s3_dly, s4_dly;

  assign early = cfg_q[CFG_EARLY_BIT];
  assign s3_dly = cfg_q[CFG_S3_LSB +: CFG_DLY_W];
  assign s4_dly = cfg_q[CFG_S4_LSB +: CFG_DLY_W];
  assign mem_cyc = (kind_d != KIND_CFG);
  assign addr_ph = ph_between(phase_d, PH_T1, PH_T2);
  assign act_ph = ph_between(phase_d, PH_T2, PH_T5);
  // Row strobe is never bank gated, so every read, write or refresh cycle refreshes a row
  assign s1_on = mem_cyc && ph_between(phase_d, PH_T2, PH_T4); // see [R17]
  // Column strobe falls at T3 and rises at T6, so waits stretch it
  assign col_on = mem_cyc && ph_between(phase_d, PH_T3, PH_T5); // see [R4] see [R8]
  assign s3_on = mem_cyc && act_ph && dly_reached(tcnt_d, s3_dly); // see [R13]
  // Strobe four runs in the boot configuration so ROM reads can wait
  assign s4_on = act_ph && dly_reached(tcnt_d, s4_dly); // see [R13]
  assign rd_on = (kind_d == KIND_READ || kind_d == KIND_CFG)
                 && ph_between(phase_d, PH_T3, PH_T5); // see [R7]
  // Early write drops byte strobes with the column strobe at T3
  assign wr_on = (kind_d == KIND_WRITE)
                 && ph_between(phase_d, early ? PH_T3 : PH_T4, PH_T5); // see [R4]

  logic [DW-1:0] ad_out_d;
  logic oe_n_d;
  logic drive_data;

  assign drive_data = (kind_d == KIND_WRITE)
                      && ph_between(phase_d, PH_T3, PH_T5);
  // Line zero carries the write indicator during the address phases
  assign ad_out_d = addr_ph ? {addr_d[AW-1:1], kind_d != KIND_WRITE} :
                    drive_data ? wdata_d : ad_out_q; // see [R12]
  // Released from T3 on reads and from T6 on writes; others must float by the next T1
  assign oe_n_d = !(addr_ph || drive_data); // see [R10]

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_q <= PH_IDLE;
      kind_q <= KIND_READ;
      tcnt_q <= '0;
      addr_q <= '0;
      wdata_q <= '0;
      be_q <= '0;
    end else begin
      phase_q <= phase_d;
      kind_q <= kind_d;
      tcnt_q <= tcnt_d;
      addr_q <= addr_d;
      wdata_q <= wdata_d;
      be_q <= be_d;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ad_out_q <= '0;
      oe_n_q <= 1'b1;
      as_n_q <= 1'b1;
      s1_n_q <= 1'b1;
      s2_n_q <= 1'b1;
      s3_n_q <= 1'b1;
      s4_n_q <= 1'b1;
      rd_n_q <= 1'b1;
      wr_n_q <= '1;
    end else begin
      ad_out_q <= ad_out_d;
      oe_n_q <= oe_n_d;
      as_n_q <= !act_ph;
      s1_n_q <= !s1_on;
      s2_n_q <= !col_on;
      s3_n_q <= !s3_on;
      s4_n_q <= !s4_on;
      rd_n_q <= !rd_on;
      wr_n_q <= ~(be_d & {BW{wr_on}});
    end
  end

  // Wait pin: three stages, level taken only when the last two agree
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_sync_q <= '0;
      wait_lvl_q <= 1'b0;
    end else begin
      wait_sync_q <= {wait_sync_q[1:0], wait_request};
      if (wait_sync_q[1] == wait_sync_q[2]) begin
        wait_lvl_q <= wait_sync_q[2];
      end
    end
  end

  // Configuration load, completion and refresh row bookkeeping
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_mode_q <= 1'b1;
      cfg_idx_q <= '0;
      shift_q <= '0;
      cfg_q <= CFG_DEFAULT;
      cfg_done_q <= 1'b0;
      row_q <= '0;
    end else begin
      if (t5_end && kind_q == KIND_CFG) begin
        shift_q[cfg_idx_q] <= ad_in[0]; // see [R15]
        cfg_idx_q <= cfg_idx_q + 1'b1;
        if (last_cfg) begin
          cfg_mode_q <= 1'b0;
          cfg_done_q <= 1'b1;
          cfg_q <= {ad_in[0], shift_q[CFG_BITS-2:0]};
        end
      end
      if (ref_ack) begin
        row_q <= row_q + 1'b1;
      end
    end
  end

  // Read data is taken at the end of T5, while the read strobe is low
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= '0;
      rsp_valid_q <= 1'b0;
      ready_q <= 1'b0;
    end else begin
      rsp_valid_q <= t5_end
                     && (kind_q == KIND_READ || kind_q == KIND_WRITE);
      if (t5_end && kind_q == KIND_READ) begin
        rdata_q <= ad_in;
      end
      // Refresh and the boot load hold off new requests
      ready_q <= (phase_d == PH_IDLE) && !start && !cfg_mode_q && !ref_due;
    end
  end

  assign req_ready = ready_q;
  assign rsp_valid = rsp_valid_q;
  assign rsp_rdata = rdata_q;
  assign ad_out = ad_out_q;
  assign ad_oe_n = oe_n_q;
  assign addr_latch_strobe_n = as_n_q;
  assign prog_strobe_one_n = s1_n_q;
  assign prog_strobe_two_n = s2_n_q;
  assign prog_strobe_three_n = s3_n_q;
  assign prog_strobe_four_n = s4_n_q;
  assign read_strobe_n = rd_n_q;
  assign byte_write_strobe_n = wr_n_q;
  assign cfg_done = cfg_done_q;

endmodule // mif_core

`default_nettype wire

// file: tb/mif_core_checker.sv
/*
  Pin-level assertions for the memory interface sequencer.
  Bound to mif_core from the bench top; sees only its ports.
*/
`default_nettype none

module mif_core_checker
  import mif_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [DW-1:0] ad_out,
  input wire logic addr_latch_strobe_n,
  input wire logic prog_strobe_one_n,
  input wire logic prog_strobe_two_n,
  input wire logic read_strobe_n,
  input wire logic [BW-1:0] byte_write_strobe_n,
  input wire logic cfg_done
);
  // Retention limit spread over 256 rows, in 10 ns cycles
  localparam int RET_CYC = 1718;
  logic al_q;
  logic rd_q;
  logic [10:0] gap_q;
  logic [3:0] rd_cnt_q;
  wire rfr_go = !addr_latch_strobe_n && al_q &&
    ad_out[31:10] == REFRESH_BASE[31:10];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      al_q <= 1'b1;
      rd_q <= 1'b1;
      gap_q <= '0;
      rd_cnt_q <= '0;
    end else begin
      al_q <= addr_latch_strobe_n;
      rd_q <= read_strobe_n;
      gap_q <= rfr_go ? '0 : gap_q + {10'h0, ~&gap_q};
      if (!cfg_done && rd_q && !read_strobe_n) begin
        rd_cnt_q <= rd_cnt_q + 4'h1;
      end
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_col_t3;
    $fell(prog_strobe_two_n) |->
      !$past(prog_strobe_one_n) && $past(prog_strobe_one_n, 2);
  endproperty
  a_col_t3: assert property (p_col_t3)
    else $error("column strobe not at T3");

  property p_col_rd;
    $fell(read_strobe_n) && cfg_done |-> $fell(prog_strobe_two_n);
  endproperty
  a_col_rd: assert property (p_col_rd)
    else $error("read strobe apart from column strobe");

  property p_rfr_gap;
    gap_q <= RET_CYC;
  endproperty
  a_rfr_gap: assert property (p_rfr_gap)
    else $error("refresh interval too long");

  property p_rfr_addr;
    // A write with no byte enabled shows no strobe either; bit 0 tells them
    $fell(addr_latch_strobe_n) ##2 (read_strobe_n && &byte_write_strobe_n
      && $past(ad_out[0], 2))
      |-> !$past(ad_out[31], 2) && $past(ad_out[20], 2);
  endproperty
  a_rfr_addr: assert property (p_rfr_addr)
    else $error("refresh address bits wrong");

  property p_cfg_quiet;
    !cfg_done |-> &byte_write_strobe_n && prog_strobe_two_n;
  endproperty
  a_cfg_quiet: assert property (p_cfg_quiet)
    else $error("memory strobe before config load");

  property p_cfg_count;
    $rose(cfg_done) |-> rd_cnt_q == 4'(CFG_BITS);
  endproperty
  a_cfg_count: assert property (p_cfg_count)
    else $error("config read count wrong");

  c_rfr: cover property (rfr_go);
  c_wr: cover property ($fell(&byte_write_strobe_n));
  c_cfg: cover property ($rose(cfg_done));
endmodule // mif_core_checker

`default_nettype wire

// file: tb/mif_mem_model.sv
/*
  Far side: DRAM banks, boot ROM and peripherals as one word store,
  with the wait gating glue. Assumes mif_core pins on one clock.
*/
`default_nettype none

module mif_mem_model
  import mif_pkg::*;
#(
  parameter logic [CFG_BITS-1:0] CFG_WORD = CFG_DEFAULT
) (
  input wire logic clk,
  input wire logic [DW-1:0] ad_out,
  input wire logic ad_oe_n,
  input wire logic addr_latch_strobe_n,
  input wire logic prog_strobe_three_n,
  input wire logic prog_strobe_four_n,
  input wire logic read_strobe_n,
  input wire logic [BW-1:0] byte_write_strobe_n,
  output logic [DW-1:0] ad_in,
  output logic wait_request
);
  logic [DW-1:0] mem [logic [29:0]];
  logic [DW-1:0] a_q;
  logic [DW-1:0] rd_d;
  logic [DW-1:0] last_q = '0;
  logic strb_q = 1'b0;
  wire [AW-1:0] cfg_off = a_q - CFG_BASE;
  wire rom = !a_q[31] && a_q[20];
  wire io = !a_q[31] && !a_q[20];

  // Address latch is open while the address strobe is high
  always @(posedge clk) begin
    if (addr_latch_strobe_n) a_q <= ad_out;
    last_q <= ad_in;
    strb_q <= !addr_latch_strobe_n &&
      (strb_q || !read_strobe_n || !(&byte_write_strobe_n));
    for (int b = 0; b < BW; b++) begin
      if (!byte_write_strobe_n[b] && !a_q[0]) begin
        mem[a_q[31:2]][8*b+:8] <= ad_out[8*b+:8];
      end
    end
  end

  always_comb begin
    rd_d = mem.exists(a_q[31:2]) ? mem[a_q[31:2]] : '0;
    // Both banks share one store, as the row strobe reaches both
    rd_d = rd_d;
    if (cfg_off < CFG_BITS * 4) rd_d = {31'h0, CFG_WORD[cfg_off[5:2]]};
  end

  // A released bus toggles so that a late sample never looks valid
  // Data reaches the bus only under the read strobe, late write or not
  assign ad_in = !ad_oe_n ? ad_out : !read_strobe_n ? rd_d : ~last_q;
  // Refresh shows no data strobe, so it never asks for waits
  assign wait_request = !addr_latch_strobe_n && strb_q &&
    (rom ? prog_strobe_four_n : io && prog_strobe_three_n);
endmodule // mif_mem_model

`default_nettype wire

// file: tb/mif_core_tb.sv
/*
  Self-checking bench for mif_core with the memory model on its pins.
  Assumes the model's config word: early write, interval select 2.
*/
`default_nettype none

module mif_core_tb
  import mif_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [CFG_BITS-1:0] CFG_WORD = 9'h16a;
  localparam int RFR_GAP = (int'(CFG_WORD[CFG_REF_LSB+:CFG_REF_W]) + 1)
    * REF_STEP_CLKIN * CLKIN_CYC;
  logic clk = 1'b0, rst_n = 1'b0, req_valid = 1'b0, req_write = 1'b0;
  logic [AW-1:0] req_addr = '0;
  logic [DW-1:0] req_wdata = '0, ad_in, ad_out, rsp_rdata;
  logic [BW-1:0] req_be = '0, byte_write_strobe_n;
  logic req_ready, rsp_valid, ad_oe_n, addr_latch_strobe_n, cfg_done;
  logic prog_strobe_one_n, prog_strobe_two_n, prog_strobe_three_n;
  logic prog_strobe_four_n, read_strobe_n, wait_request;
  logic bw_p = 1'b1, p2_p = 1'b1, al_p = 1'b1, have_p = 1'b0;
  logic idle_chk = 1'b0;
  logic [7:0] row_p;
  logic [32:0] e;
  logic [32:0] exp_q[$];
  logic [DW-1:0] shadow [logic [29:0]];
  int errors = 0, checks_done = 0, k, cyc = 0, t_p = 0, n_rfr = 0;

  always #5 clk = ~clk;

  mif_core dut (.clk, .rst_n, .req_valid, .req_write, .req_addr,
    .req_wdata, .req_be, .req_ready, .rsp_valid, .rsp_rdata, .ad_in,
    .ad_out, .ad_oe_n, .addr_latch_strobe_n, .prog_strobe_one_n,
    .prog_strobe_two_n, .prog_strobe_three_n, .prog_strobe_four_n,
    .read_strobe_n, .byte_write_strobe_n, .wait_request, .cfg_done);

  mif_mem_model #(.CFG_WORD(CFG_WORD)) u_mem (.clk, .ad_out, .ad_oe_n,
    .addr_latch_strobe_n, .prog_strobe_three_n, .prog_strobe_four_n,
    .read_strobe_n, .byte_write_strobe_n, .ad_in, .wait_request);

  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic print_verdict();
    $display("errors %0d checks %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic xfer(logic wr, logic [AW-1:0] a, logic [DW-1:0] d,
                      logic [BW-1:0] be);
    int n;
    logic [DW-1:0] w;
    w = shadow.exists(a[31:2]) ? shadow[a[31:2]] : '0;
    if (wr) begin
      for (int b = 0; b < BW; b++) if (be[b]) w[8*b+:8] = d[8*b+:8];
      shadow[a[31:2]] = w;
    end
    exp_q.push_back({!wr, w});
    req_valid <= 1'b1;
    req_write <= wr;
    req_addr <= a;
    req_wdata <= d;
    req_be <= be;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (req_ready !== 1'b1 && n < 3000);
    if (n >= 3000) errors++;
    req_valid <= 1'b0;
    @(posedge clk);
  endtask

  always @(negedge clk) begin
    cyc++;
    if (rsp_valid === 1'b1) begin
      e = exp_q.size() > 0 ? exp_q.pop_front() : 33'h1_dead_beef;
      if (e[32]) check("rdata", rsp_rdata, e[31:0]);
    end
    if (bw_p && !(&byte_write_strobe_n)) begin
      check("wr_cas", 32'({p2_p, prog_strobe_two_n}), 32'h2);
    end
    if (al_p && !addr_latch_strobe_n &&
        ad_out[31:10] == REFRESH_BASE[31:10]) begin
      if (have_p && idle_chk) begin
        check("rfr_gap", 32'(cyc - t_p), 32'(RFR_GAP));
        check("rfr_row", 32'(ad_out[9:2]), 32'(row_p + 8'h1));
      end
      n_rfr = idle_chk ? n_rfr + 1 : n_rfr;
      have_p = idle_chk;
      t_p = cyc;
      row_p = ad_out[9:2];
    end
    bw_p = &byte_write_strobe_n;
    p2_p = prog_strobe_two_n;
    al_p = addr_latch_strobe_n;
  end

  initial begin
    logic [AW-1:0] a;
    void'($urandom(32'hc6046e21));
    repeat (10) @(posedge clk);
    check("rst", 32'({read_strobe_n, ad_oe_n, req_ready}), 32'h6);
    rst_n <= 1'b1;
    k = 0;
    while (cfg_done !== 1'b1 && k < 500) begin
      @(posedge clk);
      k++;
    end
    check("cfg", 32'(cfg_done), 32'h1);
    // Every decode code in turn, few words so reads hit earlier writes
    for (int i = 0; i < 40; i++) begin
      a = {i[1], 10'h0, i[0], 2'b01, 14'h0, 2'($urandom), 2'b00};
      xfer(1'($urandom), a, $urandom, 4'($urandom));
    end
    k = 0;
    while (exp_q.size() > 0 && k < 200) begin
      @(posedge clk);
      k++;
    end
    check("drain", 32'(exp_q.size()), 32'h0);
    idle_chk = 1'b1;
    repeat (3 * RFR_GAP + 50) @(posedge clk);
    check("rfr_n", 32'(n_rfr >= 3), 32'h1);
    print_verdict();
  end

  initial begin
    #(20000 * 10);
    errors++;
    print_verdict();
  end
endmodule // mif_core_tb

bind mif_core mif_core_checker u_chk (.clk(clk), .rst_n(rst_n),
  .ad_out(ad_out), .addr_latch_strobe_n(addr_latch_strobe_n),
  .prog_strobe_one_n(prog_strobe_one_n),
  .prog_strobe_two_n(prog_strobe_two_n), .read_strobe_n(read_strobe_n),
  .byte_write_strobe_n(byte_write_strobe_n), .cfg_done(cfg_done));

`default_nettype wire
